// [verilog/jsk_pkg.sv]
package jsk_pkg;
  // Device register offsets
  localparam logic [7:0] OFS_MAKER = 8'h0c;
  localparam logic [7:0] OFS_VERSION = 8'h0d;
  localparam logic [7:0] OFS_REVISION = 8'h0e;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h0f;
  localparam logic [7:0] OFS_X = 8'h10;
  localparam logic [7:0] OFS_Y = 8'h11;
  localparam logic [7:0] OFS_XP = 8'h12;
  localparam logic [7:0] OFS_XN = 8'h13;
  localparam logic [7:0] OFS_YP = 8'h14;
  localparam logic [7:0] OFS_YN = 8'h15;
  localparam logic [7:0] OFS_C4M_HI = 8'h16;
  localparam logic [7:0] OFS_C4M_LO = 8'h17;
  localparam logic [7:0] OFS_C4P_HI = 8'h18;
  localparam logic [7:0] OFS_C4P_LO = 8'h19;
  localparam logic [7:0] OFS_SCALE = 8'h2d;
  localparam logic [7:0] OFS_CTRL2 = 8'h2e;

  // Device reset values
  localparam logic [7:0] RST_MODE_CTRL = 8'hf0;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_POS_THR = 8'h05;
  localparam logic [7:0] RST_NEG_THR = 8'hfb;
  localparam logic [7:0] RST_SCALE = 8'h09;
  localparam logic [7:0] RST_CTRL2 = 8'h84;
  localparam logic [11:0] RST_SAMPLE = 12'h000;

  // Mode/interrupt control and second control fields
  localparam int MC_IDLE_BIT = 7;
  localparam int MC_LP_MSB = 6;
  localparam int MC_LP_LSB = 4;
  localparam int MC_IRQ_DIS_BIT = 3;
  localparam int MC_IRQ_THR_BIT = 2;
  localparam int MC_SOFT_RST_BIT = 1;
  localparam int MC_VALID_BIT = 0;
  localparam int C2_INV_BIT = 1;

  // Threshold array index
  localparam int THR_XP = 0;
  localparam int THR_XN = 1;
  localparam int THR_YP = 2;
  localparam int THR_YN = 3;

  // Coordinate datapath
  localparam int RAW_W = 12;
  localparam int SCALE_SHIFT = 4;

  // Host controller APB map
  localparam logic [11:0] HOST_CMD = 12'h000;
  localparam logic [11:0] HOST_STATUS = 12'h004;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;

  typedef enum logic [0:0] {HS_IDLE, HS_WAIT} host_state_t;
endpackage

// [verilog/jsk_link_if.sv]
`timescale 1ns/100ps
interface jsk_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic irq_n_out;
  logic irq_n_oe;
  logic irq_n;

  // Open-drain line with pull-up
  assign irq_n = irq_n_oe ? irq_n_out : 1'b1;

  modport device (input req, input we, input addr, input wdata, input irq_n,
                  output ack, output rdata, output irq_n_out, output irq_n_oe);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata, input irq_n);
endinterface

// [verilog/jsk_coord_scaler.sv]
`timescale 1ns/100ps
module jsk_coord_scaler
  import jsk_pkg::*;
(
  input wire logic signed [RAW_W-1:0] raw_x_i,
  input wire logic signed [RAW_W-1:0] raw_y_i,
  input wire logic [7:0] scale_i,
  input wire logic [7:0] thr_i [4],
  output logic signed [7:0] x_o,
  output logic signed [7:0] y_o,
  output logic outside_o
);
  localparam int PROD_W = RAW_W + 9;
  logic signed [RAW_W-1:0] raw [2];
  logic signed [7:0] res [2];

  assign raw[0] = raw_x_i;
  assign raw[1] = raw_y_i;

  // Scale then saturate so small magnets still reach full 8-bit range
  for (genvar a = 0; a < 2; a++) begin : g_axis
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] shifted;
    assign prod = raw[a] * $signed({1'b0, scale_i});
    assign shifted = prod >>> SCALE_SHIFT;
    always_comb begin
      if (shifted > $signed(PROD_W'(127))) begin
        res[a] = 8'sh7f;
      end else if (shifted < -$signed(PROD_W'(128))) begin
        res[a] = 8'sh80;
      end else begin
        res[a] = shifted[7:0];
      end
    end
  end

  assign x_o = res[0];
  assign y_o = res[1];
  // Left/right/top/bottom trip limits
  assign outside_o = (res[0] > $signed(thr_i[THR_XP])) || (res[0] < $signed(thr_i[THR_XN])) ||
                     (res[1] > $signed(thr_i[THR_YP])) || (res[1] < $signed(thr_i[THR_YN]));
endmodule

// [verilog/jsk_device.sv]
// Function
// - Scale register 8-bit RW, resets 09h
// - Host writes 16h to scale after power-up
// - Coordinates scaled by scale register factor
// - Second control register RW, resets 84h
// - Host keeps test bits at required values
// - Host keeps polarity invert bit zero
// - All registers reachable over the link
// - Three read-only identification bytes
// - Mode bit 7: idle one, low-power zero
// - Bits 6:4 low-power interval, reset 111
// - Bit 3 suppresses interrupt output
// - Bit 2 selects every-result or threshold interrupt
// - Writing bit 1 resets all registers
// - Bit 0 read-only coordinate-ready flag
// - Signed X/Y results; Y read clears interrupt
// - Four signed thresholds, reset 5 and FBh
// - Channel-4 samples as sign-extended high/low bytes
// - Interrupt released with Y read acknowledge
// - Thresholds act as left/right/top/bottom limits
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
module jsk_device
  import jsk_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a,   // Arbitrary value
  parameter logic [7:0] COMP_VERSION = 8'h21, // Arbitrary value
  parameter logic [7:0] SI_REVISION = 8'h03   // Arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  jsk_link_if.device link,
  input wire logic calc_start_i,
  input wire logic raw_valid_i,
  input wire logic signed [RAW_W-1:0] raw_x_i,
  input wire logic signed [RAW_W-1:0] raw_y_i,
  input wire logic signed [RAW_W-1:0] ch4_minus_sample_i,
  input wire logic signed [RAW_W-1:0] ch4_plus_sample_i,
  output logic idle_mode_o,
  output logic [2:0] lp_interval_o,
  output logic invert_polarity_o,
  output logic [7:0] coord_scale_o
);
  logic [7:0] mode_q, mode_d;
  logic valid_q, valid_d;
  logic soft_rst_q, soft_rst_d;
  logic [7:0] x_q, x_d, y_q, y_d;
  logic [7:0] thr_q [4];
  logic [7:0] thr_d [4];
  logic [7:0] scale_q, scale_d;
  logic [7:0] ctrl2_q, ctrl2_d;
  logic [RAW_W-1:0] c4m_q, c4m_d, c4p_q, c4p_d;
  logic pending_q, pending_d;
  logic ack_q, ack_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_oe_q, irq_oe_d;
  logic signed [7:0] x_new, y_new;
  logic outside;
  logic access;
  logic [7:0] rd_mux;

  jsk_coord_scaler u_scaler (
    .raw_x_i(raw_x_i),
    .raw_y_i(raw_y_i),
    .scale_i(scale_q),
    .thr_i(thr_q),
    .x_o(x_new),
    .y_o(y_new),
    .outside_o(outside)
  );

  // Host holds the request until it sees ack; one access per request
  assign access = link.req && !ack_q;

  always_comb begin
    unique case (link.addr)
      OFS_MAKER: rd_mux = MAKER_CODE;
      OFS_VERSION: rd_mux = COMP_VERSION;
      OFS_REVISION: rd_mux = SI_REVISION;
      OFS_MODE_CTRL: rd_mux = {mode_q[7:2], 1'b0, valid_q};
      OFS_X: rd_mux = x_q;
      OFS_Y: rd_mux = y_q;
      OFS_XP: rd_mux = thr_q[THR_XP];
      OFS_XN: rd_mux = thr_q[THR_XN];
      OFS_YP: rd_mux = thr_q[THR_YP];
      OFS_YN: rd_mux = thr_q[THR_YN];
      OFS_C4M_HI: rd_mux = {{4{c4m_q[11]}}, c4m_q[11:8]};
      OFS_C4M_LO: rd_mux = c4m_q[7:0];
      OFS_C4P_HI: rd_mux = {{4{c4p_q[11]}}, c4p_q[11:8]};
      OFS_C4P_LO: rd_mux = c4p_q[7:0];
      OFS_SCALE: rd_mux = scale_q;
      OFS_CTRL2: rd_mux = ctrl2_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    mode_d = mode_q;
    valid_d = valid_q;
    soft_rst_d = 1'b0;
    x_d = x_q;
    y_d = y_q;
    thr_d = thr_q;
    scale_d = scale_q;
    ctrl2_d = ctrl2_q;
    c4m_d = c4m_q;
    c4p_d = c4p_q;
    pending_d = pending_q;
    ack_d = access;
    rdata_d = rdata_q;
    if (soft_rst_q) begin
      // Whole bank back to reset values, soft reset bit included
      mode_d = RST_MODE_CTRL;
      valid_d = 1'b0;
      x_d = RST_RESULT;
      y_d = RST_RESULT;
      thr_d[THR_XP] = RST_POS_THR;
      thr_d[THR_XN] = RST_NEG_THR;
      thr_d[THR_YP] = RST_POS_THR;
      thr_d[THR_YN] = RST_NEG_THR;
      scale_d = RST_SCALE;
      ctrl2_d = RST_CTRL2;
      c4m_d = RST_SAMPLE;
      c4p_d = RST_SAMPLE;
      pending_d = 1'b0;
    end else begin
      if (access && link.we) begin
        // Read-only offsets fall through untouched
        unique case (link.addr)
          OFS_MODE_CTRL: begin
            mode_d = {link.wdata[7:2], 2'b00};
            soft_rst_d = link.wdata[MC_SOFT_RST_BIT];
          end
          OFS_XP: thr_d[THR_XP] = link.wdata;
          OFS_XN: thr_d[THR_XN] = link.wdata;
          OFS_YP: thr_d[THR_YP] = link.wdata;
          OFS_YN: thr_d[THR_YN] = link.wdata;
          OFS_SCALE: scale_d = link.wdata;
          OFS_CTRL2: ctrl2_d = link.wdata;
          default: ;
        endcase
      end
      if (access && !link.we) begin
        rdata_d = rd_mux;
        if (link.addr == OFS_Y) begin
          pending_d = 1'b0;
        end
      end
      if (calc_start_i) begin
        valid_d = 1'b0;
      end
      if (raw_valid_i) begin
        valid_d = 1'b1;
        x_d = x_new;
        y_d = y_new;
        c4m_d = ch4_minus_sample_i;
        c4p_d = ch4_plus_sample_i;
        // A new result in the clearing cycle still raises the interrupt
        if (!mode_q[MC_IRQ_THR_BIT] || outside) begin
          pending_d = 1'b1;
        end
      end
    end
    irq_oe_d = pending_d && !mode_d[MC_IRQ_DIS_BIT];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= RST_MODE_CTRL;
      valid_q <= 1'b0;
      soft_rst_q <= 1'b0;
      x_q <= RST_RESULT;
      y_q <= RST_RESULT;
      thr_q[THR_XP] <= RST_POS_THR;
      thr_q[THR_XN] <= RST_NEG_THR;
      thr_q[THR_YP] <= RST_POS_THR;
      thr_q[THR_YN] <= RST_NEG_THR;
      scale_q <= RST_SCALE;
      ctrl2_q <= RST_CTRL2;
      c4m_q <= RST_SAMPLE;
      c4p_q <= RST_SAMPLE;
      pending_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_oe_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      valid_q <= valid_d;
      soft_rst_q <= soft_rst_d;
      x_q <= x_d;
      y_q <= y_d;
      thr_q <= thr_d;
      scale_q <= scale_d;
      ctrl2_q <= ctrl2_d;
      c4m_q <= c4m_d;
      c4p_q <= c4p_d;
      pending_q <= pending_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      irq_oe_q <= irq_oe_d;
    end
  end

  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign link.irq_n_out = 1'b0;
  assign link.irq_n_oe = irq_oe_q;
  assign idle_mode_o = mode_q[MC_IDLE_BIT];
  assign lp_interval_o = mode_q[MC_LP_MSB:MC_LP_LSB];
  assign invert_polarity_o = ctrl2_q[C2_INV_BIT];
  assign coord_scale_o = scale_q;
endmodule

// [verilog/jsk_host.sv]
`timescale 1ns/100ps
module jsk_host
  import jsk_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  jsk_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_active_o
);
  host_state_t state_q, state_d;
  logic req_q, req_d;
  logic we_q, we_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rd_q, rd_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic irq_q, irq_d;
  logic apb_acc;

  assign apb_acc = psel && penable && !pready_q;

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    we_d = we_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rd_d = rd_q;
    pready_d = apb_acc;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    irq_d = !link.irq_n;
    unique case (state_q)
      HS_IDLE: begin
        // A command while busy is dropped; software polls busy first
        if (apb_acc && pwrite && paddr == HOST_CMD) begin
          addr_d = pwdata[CMD_ADDR_LSB +: 8];
          wdata_d = pwdata[CMD_DATA_LSB +: 8];
          we_d = pwdata[CMD_WRITE_BIT];
          req_d = 1'b1;
          state_d = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (link.ack) begin
          req_d = 1'b0;
          if (!we_q) begin
            rd_d = link.rdata;
          end
          state_d = HS_IDLE;
        end
      end
    endcase
    if (apb_acc) begin
      if (paddr == HOST_STATUS) begin
        if (!pwrite) begin
          prdata_d[STAT_BUSY_BIT] = (state_q == HS_WAIT);
          prdata_d[STAT_IRQ_BIT] = irq_q;
          prdata_d[STAT_RDATA_LSB +: 8] = rd_q;
        end
      end else if (paddr != HOST_CMD) begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= HS_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rd_q <= 8'h00;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rd_q <= rd_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      irq_q <= irq_d;
    end
  end

  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_active_o = irq_q;
endmodule

// [bench/jsk_link_monitor.sv]
`timescale 1ns/100ps
module jsk_link_monitor
  import jsk_pkg::*;
#(
  parameter logic [7:0] SI_REVISION = 8'h03
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic irq_n
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence taken_s;
    req && !ack;
  endsequence
  sequence y_taken_s;
    taken_s ##0 (!we && addr == OFS_Y);
  endsequence
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (taken_s |=> ack)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  req_hold_a: assert property (taken_s |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  req_drop_a: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  irq_drive_a: assert property (irq_n_oe |-> !irq_n_out && !irq_n)
    else $error("interrupt driven but line not low");
  y_release_a: assert property (y_taken_s |=> ack && !irq_n_oe)
    else $error("interrupt not released by Y read");
  revision_read_a: assert property (ack && !we && addr == OFS_REVISION |-> rdata == SI_REVISION)
    else $error("revision byte wrong");
  soft_bit_a: assert property (ack && !we && addr == OFS_MODE_CTRL |-> !rdata[MC_SOFT_RST_BIT])
    else $error("soft reset bit reads one");
endmodule

// [bench/joystick_register_bank_bench.sv]
`timescale 1ns/100ps
module joystick_register_bank_bench;
  import jsk_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, calc_start_i = 1'b0, raw_valid_i = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, d, e;
  logic pready, pslverr, irq_active_o, idle_mode_o, invert_polarity_o, sl;
  logic signed [RAW_W-1:0] raw_x_i = '0, raw_y_i = '0, ch4m = '0, ch4p = '0;
  logic [2:0] lp_interval_o;
  logic [7:0] coord_scale_o;
  logic [7:0] exp_q[$];
  logic [7:0] ofs[17] = '{OFS_MAKER, OFS_VERSION, OFS_REVISION, OFS_MODE_CTRL, OFS_X, OFS_Y,
    OFS_XP, OFS_XN, OFS_YP, OFS_YN, OFS_C4M_HI, OFS_C4M_LO, OFS_C4P_HI, OFS_C4P_LO,
    OFS_SCALE, OFS_CTRL2, 8'h2f};
  logic [7:0] rv[17] = '{8'h5a, 8'h21, 8'h03, RST_MODE_CTRL, 8'h00, 8'h00, RST_POS_THR,
    RST_NEG_THR, RST_POS_THR, RST_NEG_THR, 8'h00, 8'h00, 8'h00, 8'h00, RST_SCALE, RST_CTRL2, 8'h00};
  logic [7:0] ev[17];
  logic [11:0] px[5] = '{12'h006, 12'hffa, 12'h000, 12'h000, 12'h005};
  logic [11:0] py[5] = '{12'h000, 12'h000, 12'h006, 12'hffa, 12'hffb};
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h41317440;
  jsk_link_if lnk();
  always #2.5 core_clk_i = ~core_clk_i;
  jsk_device #(.MAKER_CODE(8'h5a), .COMP_VERSION(8'h21), .SI_REVISION(8'h03)) jsk_device_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .link(lnk), .calc_start_i(calc_start_i),
    .raw_valid_i(raw_valid_i), .raw_x_i(raw_x_i), .raw_y_i(raw_y_i),
    .ch4_minus_sample_i(ch4m), .ch4_plus_sample_i(ch4p), .idle_mode_o(idle_mode_o),
    .lp_interval_o(lp_interval_o), .invert_polarity_o(invert_polarity_o),
    .coord_scale_o(coord_scale_o));
  jsk_host jsk_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(lnk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_active_o(irq_active_o));
  jsk_link_monitor #(.SI_REVISION(8'h03)) jsk_link_monitor_i (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata),
    .ack(lnk.ack), .rdata(lnk.rdata), .irq_n_out(lnk.irq_n_out), .irq_n_oe(lnk.irq_n_oe),
    .irq_n(lnk.irq_n));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Saturating scaler as the designer chose it: (raw * scale) >>> shift
  function automatic logic [7:0] sc(input logic signed [11:0] v, input logic [7:0] s);
    int p;
    p = (int'(v) * int'(s)) >>> SCALE_SHIFT;
    if (p > 127) p = 127;
    if (p < -128) p = -128;
    return p[7:0];
  endfunction

  task automatic chk8(input string n, input logic [7:0] ex, input logic [7:0] s);
    n_checks++;
    if (s !== ex) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, ex, s);
    end
  endtask

  task automatic close_out();
    chk8("reads left", 8'h00, 8'(exp_q.size()));
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    r = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lop(input logic w, input logic [7:0] a, input logic [7:0] wd);
    apb(1'b1, HOST_CMD, {15'h0, w, wd, a});
    do apb(1'b0, HOST_STATUS, 32'h0); while (r[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    exp_q.push_back(ex);
    lop(1'b0, a, 8'h00);
  endtask

  task automatic conv(input logic [11:0] x, input logic [11:0] y, input logic fin);
    logic [31:0] t0;
    logic [31:0] t1;
    t0 = rnd();
    t1 = rnd();
    @(posedge core_clk_i);
    calc_start_i <= 1'b1;
    @(posedge core_clk_i);
    calc_start_i <= 1'b0;
    raw_valid_i <= fin;
    raw_x_i <= x;
    raw_y_i <= y;
    ch4m <= t0[11:0];
    ch4p <= t1[11:0];
    @(posedge core_clk_i);
    raw_valid_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask

  // Every link read is matched against the oldest expectation
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("ERROR timeout expected done seen hang");
      close_out();
    end else if (!rst_i && lnk.ack === 1'b1 && lnk.we === 1'b0) begin
      if (exp_q.size() == 0) chk8("unexpected read", 8'h00, 8'hxx);
      else chk8("rdata", exp_q.pop_front(), lnk.rdata);
    end
  end

  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 17; i++) rd(ofs[i], rv[i]);
    chk8("dev out", 8'hf0, {idle_mode_o, lp_interval_o, invert_polarity_o, 3'h0});
    apb(1'b0, 12'h008, 32'h0);
    chk8("pslverr", 8'h01, {7'h0, sl});
    ev = rv;
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      if (i == 15) d[7:0] = RST_CTRL2;
      if (i != 3) lop(1'b1, ofs[i], d[7:0]);
      if (i inside {[6:9], 14}) ev[i] = d[7:0];
    end
    for (int i = 0; i < 17; i++) rd(ofs[i], ev[i]);
    chk8("scale out", ev[14], coord_scale_o);
    // Soft reset with other bits set; everything must come back
    lop(1'b1, OFS_MODE_CTRL, 8'h5e);
    for (int i = 0; i < 17; i++) rd(ofs[i], rv[i]);
    lop(1'b1, OFS_SCALE, 8'h16);
    lop(1'b1, OFS_MODE_CTRL, 8'h70);
    chk8("dev out", 8'h70, {idle_mode_o, lp_interval_o, invert_polarity_o, 3'h0});
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 32'h7ff : rnd();
      e = (k == 0) ? 32'h800 : rnd();
      conv(d[11:0], e[11:0], 1'b1);
      chk8("irq line", 8'h00, {7'h0, lnk.irq_n});
      chk8("irq status", 8'h01, {7'h0, irq_active_o});
      apb(1'b0, HOST_STATUS, 32'h0);
      chk8("irq bit", 8'h01, {7'h0, r[STAT_IRQ_BIT]});
      rd(OFS_MODE_CTRL, 8'h71);
      rd(OFS_X, sc(d[11:0], 8'h16));
      rd(OFS_C4M_HI, {{4{ch4m[11]}}, ch4m[11:8]});
      rd(OFS_C4M_LO, ch4m[7:0]);
      rd(OFS_C4P_HI, {{4{ch4p[11]}}, ch4p[11:8]});
      rd(OFS_C4P_LO, ch4p[7:0]);
      rd(OFS_Y, sc(e[11:0], 8'h16));
      chk8("irq released", 8'h01, {7'h0, lnk.irq_n});
    end
    conv(12'h0, 12'h0, 1'b0);
    rd(OFS_MODE_CTRL, 8'h70);
    lop(1'b1, OFS_MODE_CTRL, 8'h78);
    conv(12'h010, 12'h020, 1'b1);
    chk8("irq masked", 8'h01, {7'h0, lnk.irq_n});
    rd(OFS_Y, sc(12'h020, 8'h16));
    lop(1'b1, OFS_SCALE, 8'h10);
    lop(1'b1, OFS_MODE_CTRL, 8'h74);
    // Left, right, top, bottom exits, then a point on the limits
    for (int k = 0; k < 5; k++) begin
      conv(px[k], py[k], 1'b1);
      chk8("irq thr", (k == 4) ? 8'h01 : 8'h00, {7'h0, lnk.irq_n});
      rd(OFS_Y, sc(py[k], 8'h10));
    end
    close_out();
  end
endmodule
